// file: rtl/dps_pkg.sv
package dps_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned KA_PERIOD_NS  = 2000;
    localparam int unsigned KA_HALF_CYC   = KA_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [7:0]  KA_HALF       = 8'(KA_HALF_CYC);

    // ****************************************************************
    // Serial burst lengths and address codes
    // ****************************************************************
    localparam logic [5:0] LEN_CFG   = 6'h08;
    localparam logic [5:0] LEN_MREF  = 6'h10;
    localparam logic [5:0] LEN_MLOOP = 6'h18;
    localparam logic [5:0] LEN_ADDR  = 6'h20;
    localparam int unsigned ADR_MSB  = 31;
    localparam logic [3:0] ADR_CFG     = 4'h0;
    localparam logic [3:0] ADR_MREF_H  = 4'h1;
    localparam logic [3:0] ADR_MLOOP   = 4'h2;
    localparam logic [3:0] ADR_CONV    = 4'h3;
    localparam logic [3:0] ADR_SLOOP_H = 4'h4;
    localparam logic [3:0] ADR_SREF    = 4'h5;
    localparam logic [3:0] ADR_STATUS  = 4'h6;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned CFG_EXTREF_BIT  = 6;
    localparam int unsigned CFG_MPFLOAT_BIT = 5;
    localparam int unsigned CFG_SDFLOAT_BIT = 4;
    localparam int unsigned CFG_STANDBY_BIT = 3;
    localparam int unsigned MLOOP_PUMP_LSB  = 18;
    localparam int unsigned MLOOP_ADAPT_LSB = 20;
    localparam int unsigned MLOOP_ALT_BIT   = 22;
    localparam int unsigned SREF_AUX_LSB    = 16;
    localparam int unsigned SREF_RFSH_LSB   = 18;
    localparam int unsigned SLOOP_LSB       = 3;

    // ****************************************************************
    // Encodings and reset values
    // ****************************************************************
    localparam logic [1:0] PUMP_FLOAT = 2'h0;
    localparam logic [1:0] PUMP_LOW   = 2'h1;
    localparam logic [1:0] PUMP_HIGH  = 2'h2;
    localparam logic [1:0] PUMP_BOTH  = 2'h3;
    localparam logic [1:0] RFSH_OFF   = 2'h3;
    localparam logic [6:0] RFSH_HALF  = 7'h04;
    localparam logic [5:0] ADAPT_BASE = 6'h08;
    localparam logic [4:0] AUX_SPAN [0:3] = '{5'h00, 5'h10, 5'h14, 5'h19};
    localparam logic [7:0]  CFG_RST   = 8'h00;
    localparam logic [15:0] HOLD_RST  = 16'h0000;
    localparam logic [23:0] WIDE_RST  = 24'h000000;
    localparam logic [6:0]  SYNC_RST  = 7'h04;

endpackage

// file: rtl/dps_serial_ctrl.sv
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module dps_serial_ctrl (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sclk_i,
    input  wire logic        sdata_i,
    input  wire logic        port_select_n_i,
    input  wire logic        mode_pin_i,
    input  wire logic        ref_osc_i,
    input  wire logic        main_vco_input_i,
    input  wire logic        sec_vco_input_i,
    output logic             main_ref_pulse_o,
    output logic             sec_ref_pulse_o,
    output logic             main_loop_pulse_o,
    output logic             sec_loop_pulse_o,
    output logic             aux_clock_out_p_o,
    output logic             aux_clock_out_n_o,
    output logic             aux_clock_out_en_o,
    output logic             external_ref_mode_o,
    output logic             refresh_clk_o,
    output logic             keep_alive_en_o,
    output logic             main_pump_high_oe_o,
    output logic             main_pump_low_oe_o,
    output logic             sec_detector_oe_o,
    output logic      [15:0] converter_level_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    localparam int unsigned I_SCLK = 0;
    localparam int unsigned I_SDAT = 1;
    localparam int unsigned I_SEL  = 2;
    localparam int unsigned I_REF  = 3;
    localparam int unsigned I_MVCO = 4;
    localparam int unsigned I_SVCO = 5;
    localparam int unsigned I_MODE = 6;

    typedef struct packed {
        logic [6:0]       sync1;
        logic [6:0]       sync2;
        logic [6:0]       prev;
        logic [31:0]      shreg;
        logic [5:0]       bitcnt;
        logic [7:0]       cfg;
        logic [15:0]      mref_hold;
        logic [15:0]      mref;
        logic [23:0]      mloop;
        logic [23:0]      sref;
        logic [15:0]      sloop_hold;
        logic [12:0]      sloop;
        logic [15:0]      conv;
        logic [3:0][17:0] cnt;
        logic [3:0]       pulse;
        logic [4:0]       aux_cnt;
        logic             aux_clk;
        logic [6:0]       rfsh_cnt;
        logic [7:0]       ka_cnt;
        logic             rfsh_clk;
        logic             adapt_act;
        logic [5:0]       adapt_cnt;
        logic             ack;
        logic [31:0]      rdat;
    } dps_state_t;

    dps_state_t       q;
    dps_state_t       d;
    logic             sclk_rise;
    logic             sel_rise;
    logic             ref_rise;
    logic             ref_ev;
    logic             standby;
    logic             mode_hi;
    logic             aux_en;
    logic             mult_off;
    logic [1:0]       aux_sel;
    logic [4:0]       span;
    logic [4:0]       aux_nxt;
    logic [4:0]       qt1;
    logic [4:0]       qt2;
    logic [4:0]       qt3;
    logic [6:0]       rfsh_lim;
    logic [5:0]       adapt_lim;
    logic [1:0]       adapt_code;
    logic [3:0]       ev;
    logic [3:0][17:0] rat;
    logic             wr_en;
    logic [3:0]       wr_addr;
    logic [31:0]      wr_data;
    logic [31:0]      wr_mask;
    logic [31:0]      old_val;
    logic [3:0]       wb_idx;
    logic [31:0]      status;

    assign sclk_rise = q.sync2[I_SCLK] & ~q.prev[I_SCLK];
    assign sel_rise  = q.sync2[I_SEL] & ~q.prev[I_SEL];
    assign ref_rise  = q.sync2[I_REF] & ~q.prev[I_REF];
    assign standby   = q.cfg[dps_pkg::CFG_STANDBY_BIT];
    assign mode_hi   = q.sync2[I_MODE];
    assign ref_ev    = ref_rise & ~standby;
    assign wb_idx    = {1'b0, wb_adr_i[4:2]};

    // ****************************************************************
    // Counter inputs
    // ****************************************************************
    assign ev  = {q.sync2[I_SVCO] & ~q.prev[I_SVCO],
                  q.sync2[I_MVCO] & ~q.prev[I_MVCO], ref_ev, ref_ev};
    assign rat[0] = {2'h0, q.mref};
    assign rat[1] = {2'h0, q.sref[15:0]};
    assign rat[2] = q.mloop[17:0];
    assign rat[3] = {5'h00, q.sloop};

    assign aux_sel = q.sref[dps_pkg::SREF_AUX_LSB +: 2];
    assign aux_en  = ~mode_hi & (aux_sel != 2'h0);
    assign span    = dps_pkg::AUX_SPAN[aux_sel];
    assign qt1     = 5'(({2'h0, span} * 7'h01) >> 2);
    assign qt2     = 5'(({2'h0, span} * 7'h02) >> 2);
    assign qt3     = 5'(({2'h0, span} * 7'h03) >> 2);
    assign aux_nxt = ((q.aux_cnt + 5'h01) >= span) ? 5'h00
                                                   : q.aux_cnt + 5'h01;

    assign mult_off = q.sref[dps_pkg::SREF_RFSH_LSB +: 2] == dps_pkg::RFSH_OFF;
    assign rfsh_lim = dps_pkg::RFSH_HALF << q.sref[dps_pkg::SREF_RFSH_LSB +: 2];
    assign adapt_code = q.mloop[dps_pkg::MLOOP_ADAPT_LSB +: 2];
    assign adapt_lim  = dps_pkg::ADAPT_BASE << (adapt_code - 2'h1);

    // ****************************************************************
    // Register read mux
    // ****************************************************************
    assign status = {24'h000000, 2'h0, q.adapt_act, q.rfsh_clk,
                     keep_alive_en_o, aux_en, external_ref_mode_o, mode_hi};

    always_comb begin
        case (wr_addr)
            dps_pkg::ADR_CFG:     old_val = {24'h000000, q.cfg};
            dps_pkg::ADR_MREF_H:  old_val = {16'h0000, q.mref_hold};
            dps_pkg::ADR_MLOOP:   old_val = {8'h00, q.mloop};
            dps_pkg::ADR_CONV:    old_val = {16'h0000, q.conv};
            dps_pkg::ADR_SLOOP_H: old_val = {16'h0000, q.sloop_hold};
            dps_pkg::ADR_SREF:    old_val = {8'h00, q.sref};
            dps_pkg::ADR_STATUS:  old_val = status;
            default:              old_val = 32'h00000000;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d       = q;
        wr_en   = 1'b0;
        wr_addr = wb_idx;
        wr_data = 32'h00000000;
        wr_mask = 32'hFFFFFFFF;
        if (ce_i) begin
            d.sync1 = {mode_pin_i, sec_vco_input_i, main_vco_input_i,
                       ref_osc_i, port_select_n_i, sdata_i, sclk_i};
            d.sync2 = q.sync1;
            d.prev  = q.sync2;
            d.ack   = 1'b0;

            // Shift only inside a frame
            if (!q.sync2[I_SEL]) begin
                if (sclk_rise) begin
                    d.shreg = {q.shreg[30:0], q.sync2[I_SDAT]};
                    if (q.bitcnt != 6'h3F) begin
                        d.bitcnt = q.bitcnt + 6'h01;
                    end
                end
            end else begin
                d.bitcnt = 6'h00;
            end

            // Frame end loads by length or address
            if (sel_rise) begin
                case (q.bitcnt)
                    dps_pkg::LEN_CFG: begin
                        wr_en   = 1'b1;
                        wr_addr = dps_pkg::ADR_CFG;
                    end
                    dps_pkg::LEN_MREF: begin
                        wr_en   = 1'b1;
                        wr_addr = dps_pkg::ADR_MREF_H;
                    end
                    dps_pkg::LEN_MLOOP: begin
                        wr_en   = 1'b1;
                        wr_addr = dps_pkg::ADR_MLOOP;
                    end
                    dps_pkg::LEN_ADDR: begin
                        wr_addr = q.shreg[dps_pkg::ADR_MSB -: 4];
                        wr_en   = wr_addr <= dps_pkg::ADR_SREF;
                    end
                    default: begin
                        wr_en = 1'b0;
                    end
                endcase
                wr_data = {8'h00, q.shreg[23:0]};
            end else if (wb_cyc_i && wb_stb_i && !q.ack) begin
                d.ack  = 1'b1;
                d.rdat = old_val;
                if (wb_we_i && wb_idx <= dps_pkg::ADR_SREF) begin
                    wr_en   = 1'b1;
                    wr_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
                    wr_data = wb_dat_i;
                end
            end
            wr_data = (old_val & ~wr_mask) | (wr_data & wr_mask);

            // Frequency dividers
            for (int i = 0; i < 4; i++) begin
                d.pulse[i] = 1'b0;
                if (ev[i]) begin
                    if (rat[i] <= 18'h00001 ||
                        q.cnt[i] >= rat[i] - 18'h00001) begin
                        d.cnt[i]   = 18'h00000;
                        d.pulse[i] = 1'b1;
                    end else begin
                        d.cnt[i] = q.cnt[i] + 18'h00001;
                    end
                end
            end

            // Auxiliary output, toggles four times per span
            if (!aux_en) begin
                d.aux_cnt = 5'h00;
                d.aux_clk = 1'b0;
            end else if (ref_ev) begin
                d.aux_cnt = aux_nxt;
                if (aux_nxt == 5'h00 || aux_nxt == qt1 ||
                    aux_nxt == qt2 || aux_nxt == qt3) begin
                    d.aux_clk = ~q.aux_clk;
                end
            end

            // Multiplier refresh and keep-alive
            if (mult_off) begin
                d.rfsh_clk = 1'b0;
                d.rfsh_cnt = 7'h00;
                d.ka_cnt   = 8'h00;
            end else if (standby) begin
                if (q.ka_cnt >= dps_pkg::KA_HALF - 8'h01) begin
                    d.ka_cnt   = 8'h00;
                    d.rfsh_clk = ~q.rfsh_clk;
                end else begin
                    d.ka_cnt = q.ka_cnt + 8'h01;
                end
            end else if (ref_rise) begin
                if (q.rfsh_cnt >= rfsh_lim - 7'h01) begin
                    d.rfsh_cnt = 7'h00;
                    d.rfsh_clk = ~q.rfsh_clk;
                end else begin
                    d.rfsh_cnt = q.rfsh_cnt + 7'h01;
                end
            end

            // Adapt timer counts main reference periods
            if (q.adapt_act && q.pulse[0]) begin
                if (q.adapt_cnt >= adapt_lim - 6'h01) begin
                    d.adapt_act = 1'b0;
                    d.adapt_cnt = 6'h00;
                    if (q.mloop[dps_pkg::MLOOP_ALT_BIT]) begin
                        d.mref = q.mref_hold;
                    end
                end else begin
                    d.adapt_cnt = q.adapt_cnt + 6'h01;
                end
            end

            // Register writes; a main loop write also loads mref and sloop from the holding registers
            if (wr_en) begin
                case (wr_addr)
                    dps_pkg::ADR_CFG:     d.cfg = wr_data[7:0];
                    dps_pkg::ADR_MREF_H:  d.mref_hold = wr_data[15:0];
                    dps_pkg::ADR_MLOOP: begin
                        d.mloop     = wr_data[23:0];
                        d.mref      = q.mref_hold;
                        d.sloop     = q.sloop_hold[15:dps_pkg::SLOOP_LSB];
                        d.adapt_act = wr_data[dps_pkg::MLOOP_ADAPT_LSB +: 2]
                                      != 2'h0;
                        d.adapt_cnt = 6'h00;
                    end
                    dps_pkg::ADR_CONV:    d.conv = wr_data[15:0];
                    dps_pkg::ADR_SLOOP_H: d.sloop_hold = wr_data[15:0];
                    dps_pkg::ADR_SREF:    d.sref = wr_data[23:0];
                    default:              d.cfg = q.cfg;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q            <= '0;
            q.sync1      <= dps_pkg::SYNC_RST;
            q.sync2      <= dps_pkg::SYNC_RST;
            q.prev       <= dps_pkg::SYNC_RST;
            q.cfg        <= dps_pkg::CFG_RST;
            q.mref_hold  <= dps_pkg::HOLD_RST;
            q.sloop_hold <= dps_pkg::HOLD_RST;
            q.mloop      <= dps_pkg::WIDE_RST;
            q.sref       <= dps_pkg::WIDE_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic [1:0] pump_sel;
    logic       pump_float;
    assign pump_sel   = q.mloop[dps_pkg::MLOOP_PUMP_LSB +: 2];
    assign pump_float = q.cfg[dps_pkg::CFG_MPFLOAT_BIT];

    always_comb begin
        if (pump_float) begin
            main_pump_high_oe_o = 1'b0;
            main_pump_low_oe_o  = 1'b0;
        end else if (adapt_code != 2'h0) begin
            main_pump_high_oe_o = q.adapt_act;
            main_pump_low_oe_o  = ~q.adapt_act;
        end else begin
            main_pump_high_oe_o = pump_sel == dps_pkg::PUMP_HIGH ||
                                  pump_sel == dps_pkg::PUMP_BOTH;
            main_pump_low_oe_o  = pump_sel == dps_pkg::PUMP_LOW ||
                                  pump_sel == dps_pkg::PUMP_BOTH;
        end
    end

    assign sec_detector_oe_o   = ~q.cfg[dps_pkg::CFG_SDFLOAT_BIT];
    assign external_ref_mode_o = q.cfg[dps_pkg::CFG_EXTREF_BIT] & mode_hi;
    assign keep_alive_en_o     = standby & ~mult_off;
    assign aux_clock_out_en_o  = aux_en;
    assign aux_clock_out_p_o   = q.aux_clk;
    assign aux_clock_out_n_o   = aux_en & ~q.aux_clk;
    assign refresh_clk_o       = q.rfsh_clk;
    assign main_ref_pulse_o    = q.pulse[0];
    assign sec_ref_pulse_o     = q.pulse[1];
    assign main_loop_pulse_o   = q.pulse[2];
    assign sec_loop_pulse_o    = q.pulse[3];
    assign converter_level_o   = q.conv;
    assign wb_ack_o            = q.ack;
    assign wb_dat_o            = q.rdat;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    shift_msb_a: assert property (
        ce_i && sclk_rise && !q.sync2[I_SEL] |=>
        q.shreg == {$past(q.shreg[30:0]), $past(q.sync2[I_SDAT])})
        else $error("shift register did not take msb-first bit");

    idle_hold_a: assert property (
        q.sync2[I_SEL] && q.prev[I_SEL] |=> $stable(q.shreg) && q.bitcnt == 6'h00)
        else $error("shift register moved while deselected");

    cfg_load_a: assert property (
        ce_i && sel_rise && q.bitcnt == dps_pkg::LEN_CFG |=>
        q.cfg == $past(q.shreg[7:0]))
        else $error("8-clock burst did not load config");

    ratio_xfer_a: assert property (
        ce_i && wr_en && wr_addr == dps_pkg::ADR_MLOOP |=>
        q.mref == $past(q.mref_hold) && q.sloop == $past(q.sloop_hold[15:3]))
        else $error("holding registers not transferred");

    bad_len_a: assert property (
        ce_i && sel_rise && q.bitcnt != dps_pkg::LEN_CFG &&
        q.bitcnt != dps_pkg::LEN_MREF && q.bitcnt != dps_pkg::LEN_MLOOP &&
        q.bitcnt != dps_pkg::LEN_ADDR |=>
        $stable(q.cfg) && $stable(q.mloop) && $stable(q.sref) && $stable(q.conv))
        else $error("odd-length burst changed a register");

    ext_ref_a: assert property (
        external_ref_mode_o |-> q.cfg[dps_pkg::CFG_EXTREF_BIT] && mode_hi)
        else $error("external reference mode without its conditions");

    aux_mode_a: assert property (
        aux_clock_out_en_o |-> !mode_hi)
        else $error("aux output active with mode pin high");

    pump_float_a: assert property (
        pump_float |-> !main_pump_high_oe_o && !main_pump_low_oe_o)
        else $error("main pumps driven while forced to float");

    adapt_pump_a: assert property (
        q.adapt_act && !pump_float |-> main_pump_high_oe_o && !main_pump_low_oe_o)
        else $error("adapt phase lost high pump");

    ref_div_a: assert property (
        ce_i && ev[0] && rat[0] > 18'h00001 && q.cnt[0] == rat[0] - 18'h00001
        |=> q.pulse[0] ##1 !q.pulse[0] || !ce_i)
        else $error("main reference counter missed its terminal count");

    sec_float_a: assert property (
        q.cfg[dps_pkg::CFG_SDFLOAT_BIT] |-> !sec_detector_oe_o)
        else $error("secondary detector driven while forced to float");

endmodule

// file: tb/dps_host.sv
`timescale 1ns/1ps
module dps_host (
    input  wire logic clk_i,
    output logic      sclk_o,
    output logic      sdata_o,
    output logic      sel_n_o
);
    initial begin
        sclk_o = 1'h0;
        sdata_o = 1'h0;
        sel_n_o = 1'h1;
    end
    task automatic tick(input logic s);
        repeat (4) @(posedge clk_i);
        sclk_o <= s;
    endtask
    // En low gives stray clocks with select held high
    task automatic send(input int n, input logic [31:0] w, input logic en);
        sel_n_o <= ~en;
        for (int i = n - 1; i >= 0; i--) begin
            sdata_o <= w[i];
            tick(1'h1);
            tick(1'h0);
        end
        repeat (4) @(posedge clk_i);
        sel_n_o <= 1'h1;
        sdata_o <= ~sdata_o;
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, mode_pin_i = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, sclk_i, sdata_i, port_select_n_i, ref_osc_i = 1'h0;
    logic main_vco_input_i, sec_vco_input_i, main_ref_pulse_o;
    logic sec_ref_pulse_o, main_loop_pulse_o, sec_loop_pulse_o;
    logic aux_clock_out_p_o, aux_clock_out_n_o, aux_clock_out_en_o;
    logic external_ref_mode_o, refresh_clk_o, keep_alive_en_o;
    logic main_pump_high_oe_o, main_pump_low_oe_o, sec_detector_oe_o;
    logic [15:0] converter_level_o;
    int miscompares = 0, tests_run = 0;
    int pc [5] = '{default: 0};
    logic rprev;
    assign main_vco_input_i = ref_osc_i;
    assign sec_vco_input_i = ~ref_osc_i;
    always #5 clk_i = ~clk_i;
    always begin
        repeat (3) @(posedge clk_i);
        ref_osc_i <= ~ref_osc_i;
    end
    dps_serial_ctrl dut (.*);
    dps_host host (.clk_i(clk_i), .sclk_o(sclk_i), .sdata_o(sdata_i),
                   .sel_n_o(port_select_n_i));
    task automatic chk(input string s, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [2:0] i,
                      input logic [31:0] d);
        int n;
        n = 0;
        {wb_cyc_i, wb_stb_i} <= 2'h3;
        wb_we_i <= w;
        wb_adr_i <= {3'h0, i, 2'h0};
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'h1 && ++n < 40);
        if (wb_ack_o !== 1'h1) begin
            miscompares++;
            complete_run();
        end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge clk_i);
    endtask
    task automatic rc(input logic [2:0] i, input logic [31:0] e,
                      input string s);
        wb(1'h0, i, 32'h0);
        chk(s, e, rd);
    endtask
    task automatic complete_run();
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk_i);
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (4) @(posedge clk_i);
        rc(3'h0, 32'h0, "cfg reset");
        chk("sdet", 32'h1, 32'(sec_detector_oe_o));
        host.send(8, 32'h70, 1'h1);
        rc(3'h0, 32'h70, "cfg short");
        chk("sdet float", 32'h0, 32'(sec_detector_oe_o));
        mode_pin_i <= 1'h1;
        repeat (4) @(posedge clk_i);
        chk("ext on", 32'h1, 32'(external_ref_mode_o));
        mode_pin_i <= 1'h0;
        repeat (4) @(posedge clk_i);
        chk("ext off", 32'h0, 32'(external_ref_mode_o));
        host.send(16, 32'hA5C3, 1'h1);
        rc(3'h1, 32'hA5C3, "mref hold");
        host.send(32, 32'h4000ABCD, 1'h1);
        rc(3'h4, 32'hABCD, "sloop hold");
        host.send(12, 32'hFFF, 1'h1);
        host.send(8, 32'h0F, 1'h0);
        rc(3'h0, 32'h70, "cfg kept");
        wb(1'h1, 3'h0, 32'h0);
        for (int p = 1; p < 4; p++) begin
            wb(1'h1, 3'h2, 32'(p << 18) | 32'h5);
            chk("pump", 32'(p), 32'({main_pump_high_oe_o,
                main_pump_low_oe_o}));
        end
        wb(1'h1, 3'h0, 32'h20);
        chk("pump float", 32'h0, 32'({main_pump_high_oe_o,
            main_pump_low_oe_o}));
        // Ratio 20 keeps the aux divisor legal
        wb(1'h1, 3'h5, 32'h10014);
        chk("aux on", 32'h1, 32'(aux_clock_out_en_o));
        mode_pin_i <= 1'h1;
        repeat (4) @(posedge clk_i);
        chk("aux off", 32'h0, 32'(aux_clock_out_en_o));
        wb(1'h1, 3'h3, 32'h1234);
        chk("conv", 32'h1234, 32'(converter_level_o));
        wb(1'h1, 3'h1, 32'h4);
        wb(1'h1, 3'h4, 32'h1F);
        wb(1'h1, 3'h2, 32'h5);
        repeat (30) @(posedge clk_i);
        // Reference edge every 6 clocks; 360 spans every divider
        rprev = refresh_clk_o;
        repeat (360) begin
            @(posedge clk_i);
            pc[0] += int'(main_ref_pulse_o);
            pc[1] += int'(sec_ref_pulse_o);
            pc[2] += int'(main_loop_pulse_o);
            pc[3] += int'(sec_loop_pulse_o);
            pc[4] += int'(refresh_clk_o != rprev);
            rprev = refresh_clk_o;
        end
        chk("mref div", 32'h0F, 32'(pc[0]));
        chk("sref div", 32'h03, 32'(pc[1]));
        chk("mloop div", 32'h0C, 32'(pc[2]));
        chk("sloop div", 32'h14, 32'(pc[3]));
        chk("refresh", 32'h0F, 32'(pc[4]));
        wb(1'h1, 3'h0, 32'h0);
        wb(1'h1, 3'h2, 32'h100005);
        chk("adapt hi", 32'h2, 32'({main_pump_high_oe_o,
            main_pump_low_oe_o}));
        repeat (300) @(posedge clk_i);
        chk("adapt lo", 32'h1, 32'({main_pump_high_oe_o,
            main_pump_low_oe_o}));
        wb(1'h1, 3'h0, 32'h08);
        chk("keep on", 32'h1, 32'(keep_alive_en_o));
        wb(1'h1, 3'h5, 32'hC0014);
        chk("keep off", 32'h0, 32'(keep_alive_en_o));
        // Frame sent while frozen is lost
        ce_i <= 1'h0;
        host.send(8, 32'h55, 1'h1);
        ce_i <= 1'h1;
        rc(3'h0, 32'h08, "cfg frozen");
        wb(1'h1, 3'h6, 32'hFF);
        rc(3'h7, 32'h0, "unmapped");
        complete_run();
    end
endmodule
